// ---- mcfdw_consts.svh ----
`ifndef MCFDW_CONSTS_SVH
`define MCFDW_CONSTS_SVH
// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define MCFDW_ADDR_CFG18 8'h00
`define MCFDW_ADDR_CFG19 8'h04
`define MCFDW_ADDR_CFG20 8'h08
`define MCFDW_ADDR_CFG21 8'h0C
`define MCFDW_ADDR_FCDLY 8'h10
`define MCFDW_ADDR_STAT 8'h14
`define MCFDW_ADDR_CMD 8'h18
// ---------------------------------------------------------------
// Reset values of configuration bytes
// ---------------------------------------------------------------
`define MCFDW_RST_PRI_THR 3'h7
`define MCFDW_RST_CFG19 8'h80
`define MCFDW_RST_PRI_LOC 1'h1
`define MCFDW_RST_FCDLY 16'h4000
// ---------------------------------------------------------------
// Field positions in configuration byte 19
// ---------------------------------------------------------------
`define MCFDW_B19_PIN_EN 7
`define MCFDW_B19_FORCE_FD 6
`define MCFDW_B19_REJ_PAUSE 5
`define MCFDW_B19_RESTART 4
`define MCFDW_B19_RESTOP 3
`define MCFDW_B19_TXP_DIS 2
`define MCFDW_B19_PKT_WDIS 1
`define MCFDW_B19_ADDR_WAKE 0
// ---------------------------------------------------------------
// Fixed figures
// ---------------------------------------------------------------
`define MCFDW_PRI_OFF 3'h7
`define MCFDW_PRI_BYTE_NEAR 6'h13
`define MCFDW_PRI_BYTE_FAR 6'h1F
`define MCFDW_SLOT_BITS 10'h200
`define MCFDW_HOLD_BYTES 4'h8
`define MCFDW_STATUS_DONE_OK 2'h3
`define MCFDW_CLK_NS 32'h19
`define MCFDW_GAP_FULL 4'h2
`define MCFDW_GAP_HALF 4'hC
`endif

// ---- mcfdw_pkg.sv ----
package mcfdw_pkg;
  // Command sequencer states
  typedef enum logic [2:0] {
    MCFDW_IDLE = 3'b000,
    MCFDW_SAVE = 3'b001,
    MCFDW_PUSH = 3'b010,
    MCFDW_DMA = 3'b011,
    MCFDW_WAIT = 3'b100,
    MCFDW_DONE = 3'b101
  } mcfdw_seq_t;
  // Flow pause transmit states
  typedef enum logic [1:0] {
    MCFDW_FP_IDLE = 2'b00,
    MCFDW_FP_HELD = 2'b01
  } mcfdw_fp_t;
endpackage : mcfdw_pkg

// ---- mcfdw_top.sv ----
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "mcfdw_consts.svh"

// Operation
// R1: Priority above threshold marks pause as low
// R2: Threshold all ones disables priority pause
// R3: Force bit or enabled low pin gives full
// R4: Full duplex: simultaneous, sense is receive only
// R5: Reject bit keeps pause frames out of memory
// R6: Restart: pause at high, zero when empty
// R7: Restop: repeat pause on expiry if nonempty
// R8: Pause frames carry configured delay value
// R9: Received pause suspends transmit unless disabled
// R10: Predefined-frame wake disable, gated by wake enable
// R11: Address match wake gated by pme enable
// R12: Multiple address bit applies hash to individual
// R13: Priority byte 19 or 31, default 31
// R14: Multicast all accepts every multicast frame
// R15: Sequencer keeps first eight bytes only
// R16: Configure: save, push, dma, wait update
// R17: Completion status done and ok set
// R18: Selective reset keeps config, others default; soft_reset_in here reloads config defaults only
// R19: Delay counted in 512 bit slot times
// R20: New settings apply after update complete
module mcfdw_top #(
  parameter int BIT_NS = 10
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic soft_reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic duplex_select_pin_n_in,
  input wire logic rx_pause_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic [5:0] rx_byte_idx_in,
  input wire logic [15:0] rx_pause_time_in,
  input wire logic rx_fifo_high_in,
  input wire logic rx_fifo_empty_in,
  input wire logic rx_multicast_in,
  input wire logic rx_addr_match_in,
  input wire logic rx_hash_hit_in,
  input wire logic rx_frame_end_in,
  input wire logic rx_pkt_wake_in,
  input wire logic wake_enable_in,
  input wire logic pme_enable_in,
  input wire logic update_done_in,
  output logic full_duplex_out,
  output logic carrier_rx_only_out,
  output logic [3:0] min_rx_gap_out,
  output logic pause_low_out,
  output logic prio_mode_out,
  output logic rx_accept_out,
  output logic rx_to_mem_out,
  output logic tx_suspend_out,
  output logic fp_send_out,
  output logic [15:0] fp_time_out,
  output logic wake_out,
  output logic pme_out,
  output logic seq_start_out,
  output logic seq_busy_out
);
  // ---------------------------------------------------------------
  // Time figures
  // ---------------------------------------------------------------
  localparam int CLK_NS = `MCFDW_CLK_NS; // Clock period
  localparam int SLOT_NS = BIT_NS * `MCFDW_SLOT_BITS; // One slot time
  localparam int SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS; // Rounded up

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pin_s1, pin_s2; // Pin synchroniser
    logic [2:0] pri_thr; // Live threshold
    logic [7:0] cfg19; // Live byte 19
    logic multi_addr; // Live byte 20 bit 6
    logic pri_loc; // Live byte 20 bit 5
    logic mc_all; // Live byte 21 bit 3
    logic [15:0] fcdly; // Live delay
    logic [2:0] s_pri_thr; // Staged copies
    logic [7:0] s_cfg19;
    logic s_multi_addr, s_pri_loc, s_mc_all;
    logic [15:0] s_fcdly;
    logic [63:0] saved8; // First eight bytes
    logic [15:0] byte_cnt; // Configure byte count
    logic [15:0] dma_left; // Bytes left for dma
    mcfdw_pkg::mcfdw_seq_t seq;
    mcfdw_pkg::mcfdw_fp_t fp;
    logic [15:0] slot_left; // Slots left of pause
    logic [15:0] cyc_left; // Cycles in slot
    logic [15:0] tx_slots; // Received pause slots
    logic [15:0] tx_cyc;
    logic [1:0] status; // Done, ok
    logic [31:0] rdata;
    logic fd, sense_rx, pause_low, prio, accept, to_mem;
    logic tx_sus, fp_send, wake, pme, start, busy;
    logic [15:0] fp_time;
    logic [3:0] gap;
  } mcfdw_st_t;

  mcfdw_st_t st, next_st;
  logic [7:0] pin_sync; // Settled pin, one bit used
  logic [7:0] pri_sel; // Selected priority byte
  logic full_dup;
  logic high_seen;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    pin_sync = st.pin_s2;
    pri_sel = 8'h00;
    next_st.pin_s1 = {7'h00, duplex_select_pin_n_in};
    next_st.pin_s2 = st.pin_s1;
    next_st.start = 1'b0;
    next_st.fp_send = 1'b0;
    next_st.rdata = 32'h0000_0000;
    // Duplex from force bit or the active-low pin
    full_dup = st.cfg19[`MCFDW_B19_FORCE_FD] |
      (st.cfg19[`MCFDW_B19_PIN_EN] & ~pin_sync[0]); // [R3]
    next_st.fd = full_dup;
    next_st.sense_rx = full_dup; // [R4]
    next_st.gap = full_dup ? `MCFDW_GAP_FULL : `MCFDW_GAP_HALF; // [R4]
    // Priority pause classification
    next_st.prio = (st.pri_thr != `MCFDW_PRI_OFF); // [R2]
    if (rx_pause_in && rx_byte_idx_in == (st.pri_loc ? `MCFDW_PRI_BYTE_FAR
        : `MCFDW_PRI_BYTE_NEAR)) // [R13]
    begin
      pri_sel = rx_byte_in;
      next_st.pause_low = next_st.prio &&
        (pri_sel[2:0] > st.pri_thr); // [R1]
    end
    // A stale low mark must not outlive priority mode
    if (!next_st.prio)
      next_st.pause_low = 1'b0; // [R2]
    // Address acceptance at frame end
    if (rx_frame_end_in)
    begin
      next_st.accept = rx_addr_match_in
        | (rx_multicast_in & (st.mc_all | rx_hash_hit_in)) // [R14]
        | (~rx_multicast_in & st.multi_addr & rx_hash_hit_in); // [R12]
      next_st.to_mem = next_st.accept &
        ~(rx_pause_in & st.cfg19[`MCFDW_B19_REJ_PAUSE]); // [R5]
      // Wake signalling
      next_st.pme = st.cfg19[`MCFDW_B19_ADDR_WAKE] & rx_addr_match_in
        & pme_enable_in; // [R11]
      next_st.wake = rx_pkt_wake_in & wake_enable_in &
        ~st.cfg19[`MCFDW_B19_PKT_WDIS]; // [R10]
    end
    else
    begin
      next_st.wake = 1'b0;
      next_st.pme = 1'b0;
    end
    // Received pause suspends our transmitter, counted in slots
    if (rx_pause_in && rx_frame_end_in &&
        !st.cfg19[`MCFDW_B19_TXP_DIS]) // [R9]
    begin
      next_st.tx_slots = rx_pause_time_in;
      next_st.tx_cyc = 16'(SLOT_CYC); // [R19]
    end
    else if (st.tx_slots != 16'h0000)
    begin
      if (st.tx_cyc <= 16'h0001)
      begin
        next_st.tx_slots = st.tx_slots - 16'h0001;
        next_st.tx_cyc = 16'(SLOT_CYC);
      end
      else
        next_st.tx_cyc = st.tx_cyc - 16'h0001;
    end
    next_st.tx_sus = (next_st.tx_slots != 16'h0000);
    // Flow pause transmit control
    high_seen = rx_fifo_high_in & (st.cfg19[`MCFDW_B19_RESTART] |
      st.cfg19[`MCFDW_B19_RESTOP]);
    unique case (st.fp)
      mcfdw_pkg::MCFDW_FP_IDLE:
      begin
        if (high_seen)
        begin
          next_st.fp_send = 1'b1;
          next_st.fp_time = st.fcdly; // [R8]
          next_st.slot_left = st.fcdly;
          next_st.cyc_left = 16'(SLOT_CYC); // [R19]
          next_st.fp = mcfdw_pkg::MCFDW_FP_HELD;
        end
      end
      mcfdw_pkg::MCFDW_FP_HELD:
      begin
        if (st.cfg19[`MCFDW_B19_RESTART] && rx_fifo_empty_in)
        begin
          next_st.fp_send = 1'b1;
          next_st.fp_time = 16'h0000; // [R6]
          next_st.fp = mcfdw_pkg::MCFDW_FP_IDLE;
        end
        else if (st.slot_left == 16'h0000)
        begin
          // Delay expired
          if (st.cfg19[`MCFDW_B19_RESTOP] && !rx_fifo_empty_in)
          begin
            next_st.fp_send = 1'b1;
            next_st.fp_time = st.fcdly; // [R7] [R8]
            next_st.slot_left = st.fcdly;
            next_st.cyc_left = 16'(SLOT_CYC);
          end
          else if (!st.cfg19[`MCFDW_B19_RESTART])
            next_st.fp = mcfdw_pkg::MCFDW_FP_IDLE;
        end
        else if (st.cyc_left <= 16'h0001)
        begin
          next_st.slot_left = st.slot_left - 16'h0001;
          next_st.cyc_left = 16'(SLOT_CYC);
        end
        else
          next_st.cyc_left = st.cyc_left - 16'h0001;
      end
      default:
        next_st.fp = mcfdw_pkg::MCFDW_FP_IDLE;
    endcase
    // Command sequencer for configure
    unique case (st.seq)
      mcfdw_pkg::MCFDW_IDLE:
      begin
        if (wr_in && addr_in == `MCFDW_ADDR_CMD)
        begin
          next_st.start = 1'b1; // [R16]
          next_st.busy = 1'b1;
          next_st.status = 2'h0;
          next_st.byte_cnt = wdata_in[15:0];
          next_st.seq = mcfdw_pkg::MCFDW_SAVE;
        end
      end
      mcfdw_pkg::MCFDW_SAVE:
      begin
        next_st.saved8 = {wdata_in, wdata_in}; // [R15]
        next_st.seq = mcfdw_pkg::MCFDW_PUSH;
      end
      mcfdw_pkg::MCFDW_PUSH:
      begin
        // Command word enters the transmit fifo
        next_st.dma_left = (st.byte_cnt > 16'(`MCFDW_HOLD_BYTES)) ?
          st.byte_cnt - 16'(`MCFDW_HOLD_BYTES) : 16'h0000; // [R15]
        next_st.seq = mcfdw_pkg::MCFDW_DMA;
      end
      mcfdw_pkg::MCFDW_DMA:
      begin
        if (st.dma_left == 16'h0000)
          next_st.seq = mcfdw_pkg::MCFDW_WAIT;
        else
          next_st.dma_left = st.dma_left - 16'h0001; // [R16]
      end
      mcfdw_pkg::MCFDW_WAIT:
      begin
        if (update_done_in) // [R20]
        begin
          next_st.pri_thr = st.s_pri_thr;
          next_st.cfg19 = st.s_cfg19;
          next_st.multi_addr = st.s_multi_addr;
          next_st.pri_loc = st.s_pri_loc;
          next_st.mc_all = st.s_mc_all;
          next_st.fcdly = st.s_fcdly;
          next_st.seq = mcfdw_pkg::MCFDW_DONE;
        end
      end
      mcfdw_pkg::MCFDW_DONE:
      begin
        next_st.status = `MCFDW_STATUS_DONE_OK; // [R17]
        next_st.busy = 1'b0;
        next_st.seq = mcfdw_pkg::MCFDW_IDLE;
      end
      default:
        next_st.seq = mcfdw_pkg::MCFDW_IDLE;
    endcase
    // Register writes go to the staged copies
    if (wr_in)
    begin
      unique case (addr_in)
        `MCFDW_ADDR_CFG18: next_st.s_pri_thr = wdata_in[6:4];
        `MCFDW_ADDR_CFG19: next_st.s_cfg19 = wdata_in[7:0];
        `MCFDW_ADDR_CFG20:
        begin
          next_st.s_multi_addr = wdata_in[6];
          next_st.s_pri_loc = wdata_in[5];
        end
        `MCFDW_ADDR_CFG21: next_st.s_mc_all = wdata_in[3];
        `MCFDW_ADDR_FCDLY: next_st.s_fcdly = wdata_in[15:0];
        default: ;
      endcase
    end
    // Reads show live settings and sequencer state
    if (rd_in)
    begin
      unique case (addr_in)
        `MCFDW_ADDR_CFG18: next_st.rdata = {25'h0, st.pri_thr, 4'h0};
        `MCFDW_ADDR_CFG19: next_st.rdata = {24'h0, st.cfg19};
        `MCFDW_ADDR_CFG20:
          next_st.rdata = {25'h0, st.multi_addr, st.pri_loc, 5'h00};
        `MCFDW_ADDR_CFG21: next_st.rdata = {28'h0, st.mc_all, 3'h0};
        `MCFDW_ADDR_FCDLY: next_st.rdata = {16'h0, st.fcdly};
        `MCFDW_ADDR_STAT: next_st.rdata = {27'h0, st.tx_sus,
          st.fd, st.busy, st.status};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    // Software reset returns settings to defaults
    if (soft_reset_in) // [R18]
    begin
      next_st.pri_thr = `MCFDW_RST_PRI_THR;
      next_st.s_pri_thr = `MCFDW_RST_PRI_THR;
      next_st.cfg19 = `MCFDW_RST_CFG19;
      next_st.s_cfg19 = `MCFDW_RST_CFG19;
      next_st.pri_loc = `MCFDW_RST_PRI_LOC;
      next_st.s_pri_loc = `MCFDW_RST_PRI_LOC;
      next_st.multi_addr = 1'b0;
      next_st.s_multi_addr = 1'b0;
      next_st.mc_all = 1'b0;
      next_st.s_mc_all = 1'b0;
      next_st.fcdly = `MCFDW_RST_FCDLY;
      next_st.s_fcdly = `MCFDW_RST_FCDLY;
    end
  end

  // ---------------------------------------------------------------
  // State register, hardware reset to defaults
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st <= '0; // [R18]
      st.pri_thr <= `MCFDW_RST_PRI_THR;
      st.s_pri_thr <= `MCFDW_RST_PRI_THR;
      st.cfg19 <= `MCFDW_RST_CFG19;
      st.s_cfg19 <= `MCFDW_RST_CFG19;
      st.pri_loc <= `MCFDW_RST_PRI_LOC;
      st.s_pri_loc <= `MCFDW_RST_PRI_LOC;
      st.fcdly <= `MCFDW_RST_FCDLY;
      st.s_fcdly <= `MCFDW_RST_FCDLY;
      st.gap <= `MCFDW_GAP_HALF;
      st.pin_s1 <= 8'h01;
      st.pin_s2 <= 8'h01;
    end
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs straight from state
  // ---------------------------------------------------------------
  assign rdata_out = st.rdata;
  assign full_duplex_out = st.fd;
  assign carrier_rx_only_out = st.sense_rx;
  assign min_rx_gap_out = st.gap;
  assign pause_low_out = st.pause_low;
  assign prio_mode_out = st.prio;
  assign rx_accept_out = st.accept;
  assign rx_to_mem_out = st.to_mem;
  assign tx_suspend_out = st.tx_sus;
  assign fp_send_out = st.fp_send;
  assign fp_time_out = st.fp_time;
  assign wake_out = st.wake;
  assign pme_out = st.pme;
  assign seq_start_out = st.start;
  assign seq_busy_out = st.busy;
endmodule : mcfdw_top
`default_nettype wire

// ---- mcfdw_chk_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mcfdw_consts.svh"
// ---------------------------------------------------------------
// Checks on duplex, priority, wake, pme, flow pause, sequencer and read data outputs
// ---------------------------------------------------------------
module mcfdw_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic soft_reset_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic wake_enable_in,
  input wire logic pme_enable_in,
  input wire logic update_done_in,
  input wire logic full_duplex_out,
  input wire logic carrier_rx_only_out,
  input wire logic [3:0] min_rx_gap_out,
  input wire logic pause_low_out,
  input wire logic prio_mode_out,
  input wire logic fp_send_out,
  input wire logic [15:0] fp_time_out,
  input wire logic wake_out,
  input wire logic pme_out,
  input wire logic seq_start_out,
  input wire logic seq_busy_out
);
  // One clock domain, async reset
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  AST_CRS_RX:
    assert property (carrier_rx_only_out == full_duplex_out)
    else $error("carrier view differs from duplex mode");
  AST_GAP:
    assert property (min_rx_gap_out ==
      (full_duplex_out ? `MCFDW_GAP_FULL : `MCFDW_GAP_HALF))
    else $error("reception gap does not follow duplex mode");
  AST_PRIO:
    assert property (pause_low_out |-> prio_mode_out)
    else $error("low pause seen with priority mode off");
  AST_WAKE:
    assert property (wake_out |-> $past(wake_enable_in))
    else $error("wake pulse without wake enable");
  AST_PME:
    assert property (pme_out |-> $past(pme_enable_in))
    else $error("pme pulse without pme enable");
  AST_FP_PULSE:
    assert property (fp_send_out |=> !fp_send_out)
    else $error("pause send longer than one cycle");
  AST_FP_HOLD:
    assert property (fp_send_out |=> $stable(fp_time_out))
    else $error("pause time moved after send");
  AST_SEQ_START:
    assert property ((wr_in && addr_in == `MCFDW_ADDR_CMD && !seq_busy_out
      && !soft_reset_in) |=> (seq_start_out && seq_busy_out))
    else $error("configure command did not start sequencer");
  AST_DONE_BOUND:
    assert property ((update_done_in && seq_busy_out) |-> ##[1:3] !seq_busy_out)
    else $error("sequencer stayed busy after update");
  AST_BUSY_HOLD:
    assert property (($fell(seq_busy_out) && !$past(soft_reset_in))
      |-> $past(update_done_in, 2))
    else $error("sequencer finished before update");
  AST_RD_IDLE:
    assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read cycle");
endmodule : mcfdw_chk
bind mcfdw_top mcfdw_chk u_chk (.clk_in, .rst_in, .soft_reset_in, .addr_in,
  .wr_in, .rd_in, .rdata_out, .wake_enable_in, .pme_enable_in,
  .update_done_in, .full_duplex_out, .carrier_rx_only_out, .min_rx_gap_out,
  .pause_low_out, .prio_mode_out, .fp_send_out, .fp_time_out, .wake_out,
  .pme_out, .seq_start_out, .seq_busy_out);
`default_nettype wire

// ---- mcfdw_exec_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Execution machine: reports update done, prompt or slow
// ---------------------------------------------------------------
module mcfdw_exec_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic busy_in,
  output logic done_out
);
  logic [4:0] cnt; // Cycles since sequencer went busy
  // Done held until the sequencer drops busy
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in || !busy_in)
    begin
      cnt <= 5'h00;
      done_out <= 1'b0;
    end
    else if (cnt == (slow_in ? 5'h1E : 5'h0E))
      done_out <= 1'b1;
    else
      cnt <= cnt + 5'h01;
  end
endmodule : mcfdw_exec_model
`default_nettype wire

// ---- mcfdw_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mcfdw_consts.svh"
module mcfdw_top_tb;
  // Bench drives, all valued at time zero
  logic clk_in = 0, rst_in = 1, soft_reset_in = 0, wr_in = 0, rd_in = 0;
  logic [7:0] addr_in = 8'h00, rx_byte_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic duplex_select_pin_n_in = 1, rx_pause_in = 0, rx_fifo_high_in = 0;
  logic rx_fifo_empty_in = 1, rx_multicast_in = 0, rx_addr_match_in = 0;
  logic rx_hash_hit_in = 0, rx_frame_end_in = 0, rx_pkt_wake_in = 0;
  logic wake_enable_in = 0, pme_enable_in = 0, update_done_in, slow = 0;
  logic [5:0] rx_byte_idx_in = 6'h00;
  logic [15:0] rx_pause_time_in = 16'h0, fp_time_out, d;
  logic full_duplex_out, carrier_rx_only_out, pause_low_out, prio_mode_out;
  logic rx_accept_out, rx_to_mem_out, tx_suspend_out, fp_send_out;
  logic wake_out, pme_out, seq_start_out, seq_busy_out, rdp = 0;
  logic [3:0] min_rx_gap_out;
  int failures = 0, num_checks = 0, seed = 13890;
  logic [63:0] rq[$], e; // Read notes: mask and value
  logic [15:0] fq[$]; // Pause time notes
  logic pq[$]; // Pme pulse notes
  logic wq[$]; // Wake pulse notes
  mcfdw_top #(.BIT_NS(1)) u_dut (.*);
  mcfdw_exec_model u_exec (.clk_in, .rst_in, .slow_in(slow),
    .busy_in(seq_busy_out), .done_out(update_done_in));
  always #12.5 clk_in = ~clk_in;
  // ---------------------------------------------------------------
  // Compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] x);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    rq.push_back({m, x});
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask : rd
  task automatic wait_idle();
    int n;
    @(posedge clk_in);
    for (n = 0; n < 60 && seq_busy_out !== 1'b0; n++)
      @(posedge clk_in);
    chk_bit(seq_busy_out, 1'b0);
  endtask : wait_idle
  task automatic cfg(); // Configure of sixteen bytes
    wr(`MCFDW_ADDR_CMD, 32'h10);
    wait_idle();
  endtask : cfg
  task automatic pulse_end();
    @(posedge clk_in);
    rx_frame_end_in <= 1'b1;
    @(posedge clk_in);
    rx_frame_end_in <= 1'b0;
    rx_pause_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : pulse_end
  task automatic frame(input logic [7:0] b19, input logic [7:0] b31,
    input logic x);
    int i;
    rx_pause_in <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk_in);
      rx_byte_idx_in <= i[5:0];
      rx_byte_in <= (i == 19) ? b19 : (i == 31) ? b31 : 8'($random(seed));
    end
    rx_pause_time_in <= 16'($random(seed)) | 16'h0001;
    pulse_end();
    chk_bit(pause_low_out, x);
    chk_bit(tx_suspend_out, 1'b1);
  endtask : frame
  // Filter inputs {multicast, match, hash, pause}, expect {accept, mem}
  task automatic filt(input logic [3:0] f, input logic [1:0] x);
    {rx_multicast_in, rx_addr_match_in, rx_hash_hit_in, rx_pause_in} <= f;
    pulse_end();
    chk({30'h0, rx_accept_out, rx_to_mem_out}, {30'h0, x});
  endtask : filt
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // Oldest note against each result that appears
  always @(posedge clk_in)
  begin
    if (rdp)
    begin
      e = rq.pop_front();
      chk(rdata_out & e[63:32], e[31:0]);
    end
    if (fp_send_out)
      chk({16'h0, fp_time_out},
        fq.size() ? {16'h0, fq.pop_front()} : 32'hBAD);
    if (wake_out)
      chk_bit(wq.size() ? wq.pop_front() : 1'b0, 1'b1);
    if (pme_out)
      chk_bit(pq.size() ? pq.pop_front() : 1'b0, 1'b1);
    rdp <= rd_in;
  end
  // Watchdog
  initial
  begin
    #500000;
    failures++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd(`MCFDW_ADDR_CFG18, 32'h70, 32'h70);
    rd(`MCFDW_ADDR_CFG19, 32'hFF, 32'h80);
    rd(`MCFDW_ADDR_CFG20, 32'h20, 32'h20);
    rd(`MCFDW_ADDR_FCDLY, 32'hFFFF, 32'h4000);
    rd(8'h1C, 32'hFFFFFFFF, 32'h0);
    chk_bit(prio_mode_out, 1'b0);
    chk_bit(full_duplex_out, 1'b0);
    duplex_select_pin_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    chk_bit(full_duplex_out, 1'b1);
    chk({28'h0, min_rx_gap_out}, 32'h2);
    wr(`MCFDW_ADDR_CFG19, 32'h40);
    duplex_select_pin_n_in <= 1'b1;
    slow <= 1'b1;
    wr(`MCFDW_ADDR_CMD, 32'h10);
    repeat (6) @(posedge clk_in);
    chk_bit(full_duplex_out, 1'b0);
    wait_idle();
    chk_bit(full_duplex_out, 1'b1);
    rd(`MCFDW_ADDR_STAT, 32'hF, 32'hB);
    slow <= 1'b0;
    wr(`MCFDW_ADDR_CFG18, 32'h30);
    cfg();
    chk_bit(prio_mode_out, 1'b1);
    frame(8'h07, 8'h03, 1'b0);
    frame(8'h00, 8'h04, 1'b1);
    wr(`MCFDW_ADDR_CFG20, 32'h0);
    cfg();
    frame(8'h04, 8'h00, 1'b1);
    d = 16'($random(seed)) | 16'h0100;
    wr(`MCFDW_ADDR_CFG19, 32'h90);
    wr(`MCFDW_ADDR_FCDLY, {16'h0, d});
    cfg();
    rx_fifo_empty_in <= 1'b0;
    fq.push_back(d);
    fq.push_back(16'h0);
    rx_fifo_high_in <= 1'b1;
    @(posedge clk_in);
    rx_fifo_high_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rx_fifo_empty_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk(fq.size(), 32'h0);
    wr(`MCFDW_ADDR_CFG19, 32'h88);
    wr(`MCFDW_ADDR_FCDLY, 32'h2);
    cfg();
    rx_fifo_empty_in <= 1'b0;
    fq.push_back(16'h2);
    fq.push_back(16'h2);
    rx_fifo_high_in <= 1'b1;
    @(posedge clk_in);
    rx_fifo_high_in <= 1'b0;
    repeat (40) @(posedge clk_in);
    chk(fq.size(), 32'h1);
    repeat (5) @(posedge clk_in);
    chk(fq.size(), 32'h0);
    rx_fifo_empty_in <= 1'b1;
    repeat (50) @(posedge clk_in);
    wr(`MCFDW_ADDR_CFG19, 32'h81);
    cfg();
    pme_enable_in <= 1'b1;
    wake_enable_in <= 1'b1;
    rx_addr_match_in <= 1'b1;
    pq.push_back(1'b1);
    pulse_end();
    pme_enable_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    pulse_end();
    chk(pq.size(), 32'h0);
    rx_pkt_wake_in <= 1'b1;
    wq.push_back(1'b1);
    pulse_end();
    wr(`MCFDW_ADDR_CFG19, 32'hA3);
    wr(`MCFDW_ADDR_CFG20, 32'h40);
    wr(`MCFDW_ADDR_CFG21, 32'h08);
    cfg();
    pulse_end();
    chk(wq.size(), 32'h0);
    rx_pkt_wake_in <= 1'b0;
    filt(4'h2, 2'h3);
    filt(4'h8, 2'h3);
    filt(4'h5, 2'h2);
    soft_reset_in <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd(`MCFDW_ADDR_CFG19, 32'hFF, 32'h80);
    chk_bit(prio_mode_out, 1'b0);
    filt(4'h2, 2'h0);
    filt(4'h8, 2'h0);
    filt(4'h5, 2'h3);
    repeat (3) @(posedge clk_in);
    complete_run();
  end
endmodule : mcfdw_top_tb
`default_nettype wire
